// ---- pdc_master.sv ----
module pdc_master
    import pdc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Master's own station address
    input wire logic [5:0] own_mac_i,
    // Command request from the master application
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire pdc_cmd_t cmd_kind_i,
    input wire logic [5:0] cmd_mac_i,
    // Identifier to the CAN controller
    output logic tx_valid_o,
    input wire logic tx_ready_i,
    output logic [10:0] tx_id_o,
    // Identifier from the CAN controller
    input wire logic rx_valid_i,
    input wire logic [10:0] rx_id_i,
    // Received frame report
    output logic rx_evt_o,
    output pdc_rx_kind_t rx_kind_o,
    output logic [5:0] rx_mac_o,
    output logic rx_expected_o,
    // Connection status
    output logic expl_open_o,
    output logic io_open_o,
    output logic cmd_error_o
);

    // ------------------------------------------------------------
    // Command acceptance
    // ------------------------------------------------------------
    pdc_state_t state_reg;
    pdc_state_t state_next;
    logic [5:0] target_reg;
    logic tx_busy_reg;
    logic cmd_ok;
    logic [10:0] id_next;
    logic take;

    always_comb
    begin
        // I/O commands are refused until the I/O connection exists
        cmd_ok = 1'b1;
        case (cmd_kind_i)
            PDC_CMD_POLL, PDC_CMD_STROBE, PDC_CMD_MC_POLL, PDC_CMD_COS_ACK:
                cmd_ok = (state_reg == PDC_ST_IO);
            default:
                cmd_ok = 1'b1;
        endcase
        if (cmd_mac_i > MAC_MAX)
            cmd_ok = 1'b0;
    end

    always_comb
    begin
        case (cmd_kind_i)
            PDC_CMD_STROBE:
                id_next = pdc_g2_id(own_mac_i, G2_STROBE_CMD);
            PDC_CMD_MC_POLL:
                id_next = pdc_g2_id(cmd_mac_i, G2_MC_POLL_CMD);
            PDC_CMD_COS_ACK:
                id_next = pdc_g2_id(cmd_mac_i, G2_COS_ACK);
            PDC_CMD_EXPL:
                id_next = pdc_g2_id(cmd_mac_i, G2_EXPL_REQ);
            PDC_CMD_POLL:
                id_next = pdc_g2_id(cmd_mac_i, G2_POLL_CMD);
            PDC_CMD_UNCONN:
                id_next = pdc_g2_id(cmd_mac_i, G2_UNCONN_REQ);
            default:
                id_next = pdc_g2_id(cmd_mac_i, G2_DUP_CHECK);
        endcase
    end

    assign cmd_ready_o = !tx_busy_reg;
    assign take = cmd_valid_i && cmd_ready_o;
    assign tx_valid_o = tx_busy_reg;

    // ------------------------------------------------------------
    // Transmit holding register
    // ------------------------------------------------------------
    // One identifier in flight; a second command waits on cmd_ready_o
    // so an identifier on offer can never be overwritten
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            tx_busy_reg <= 1'b0;
            tx_id_o <= 11'h000;
        end
        else if (take && cmd_ok)
        begin
            tx_busy_reg <= 1'b1;
            tx_id_o <= id_next;
        end
        else if (tx_busy_reg && tx_ready_i)
            tx_busy_reg <= 1'b0;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
            cmd_error_o <= 1'b0;
        else
            cmd_error_o <= take && !cmd_ok;
    end

    // ------------------------------------------------------------
    // Connection state
    // ------------------------------------------------------------
    // Opening is counted on explicit request issue, and the I/O
    // connection on the explicit answer of the explicit target.
    // Only a reset closes a connection; there is no close command.
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            PDC_ST_IDLE:
                if (take && cmd_ok && cmd_kind_i == PDC_CMD_EXPL)
                    state_next = PDC_ST_EXPL;
            PDC_ST_EXPL:
                if (rx_evt_o && rx_kind_o == PDC_RX_EXPL_RSP
                    && rx_mac_o == target_reg)
                    state_next = PDC_ST_IO;
            PDC_ST_IO:
                state_next = PDC_ST_IO;
            default:
                state_next = PDC_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
            state_reg <= PDC_ST_IDLE;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
            target_reg <= MAC_DEFAULT;
        else if (take && cmd_ok && cmd_kind_i == PDC_CMD_EXPL)
            target_reg <= cmd_mac_i;
    end

    assign expl_open_o = (state_reg != PDC_ST_IDLE);
    assign io_open_o = (state_reg == PDC_ST_IO);

    // ------------------------------------------------------------
    // Receive side
    // ------------------------------------------------------------
    pdc_group_t dec_group;

    pdc_rx_decode u_rx_decode (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .rx_valid_i(rx_valid_i),
        .rx_id_i(rx_id_i),
        .dec_valid_o(rx_evt_o),
        .dec_group_o(dec_group),
        .dec_kind_o(rx_kind_o),
        .dec_mac_o(rx_mac_o)
    );

    // Frames from other slaves are reported but flagged unexpected
    // A report left over from reset is never expected
    always_comb
    begin
        rx_expected_o = 1'b0;
        if (dec_group == PDC_GRP_1 || dec_group == PDC_GRP_2)
            rx_expected_o = (rx_mac_o == target_reg)
                            && (rx_kind_o != PDC_RX_NONE)
                            && (rx_kind_o != PDC_RX_OTHER);
    end

    // hold on the bus and in the slaves; the CAN
    // controller arbitrates, and group one answers outrank commands.

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_poll_needs_io: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        cmd_valid_i && cmd_ready_o && cmd_kind_i == PDC_CMD_POLL
        && !io_open_o |=> !tx_valid_o && cmd_error_o)
        else $error("poll sent without connection");

    a_strobe_format: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        take && cmd_ok && cmd_kind_i == PDC_CMD_STROBE
        |=> tx_id_o == {G2_PREFIX, $past(own_mac_i), G2_STROBE_CMD})
        else $error("strobe identifier wrong");

    a_expl_format: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        take && cmd_ok && cmd_kind_i == PDC_CMD_EXPL
        |=> tx_valid_o && tx_id_o[8:3] == $past(cmd_mac_i)
        && tx_id_o[2:0] == G2_EXPL_REQ)
        else $error("explicit identifier wrong");

    a_poll_format: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        take && cmd_ok && cmd_kind_i == PDC_CMD_POLL
        |=> tx_id_o[2:0] == G2_POLL_CMD
        && tx_id_o[8:3] == $past(cmd_mac_i))
        else $error("poll identifier wrong");

    a_mc_poll_code: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        take && cmd_ok && cmd_kind_i == PDC_CMD_MC_POLL
        |=> tx_id_o[2:0] == G2_MC_POLL_CMD
        && tx_id_o[8:3] == $past(cmd_mac_i))
        else $error("multicast poll code wrong");

    a_ack_code: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        take && cmd_ok && cmd_kind_i == PDC_CMD_COS_ACK
        |=> tx_id_o[2:0] == G2_COS_ACK
        && tx_id_o[8:3] == $past(cmd_mac_i))
        else $error("acknowledge code wrong");

    a_unconn_code: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        take && cmd_ok && cmd_kind_i == PDC_CMD_UNCONN
        |=> tx_id_o[2:0] == G2_UNCONN_REQ
        && tx_id_o[8:3] == $past(cmd_mac_i))
        else $error("unconnected request code wrong");

    a_dup_code: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        take && cmd_ok && cmd_kind_i == PDC_CMD_DUP
        |=> tx_id_o[2:0] == G2_DUP_CHECK
        && tx_id_o[8:3] == $past(cmd_mac_i))
        else $error("duplicate check code wrong");

    a_tx_in_group2: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        tx_valid_o |-> tx_id_o[10:9] == G2_PREFIX)
        else $error("command outside group two");

    a_tx_held: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_id_o))
        else $error("identifier dropped before taken");

    a_tx_release: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        tx_valid_o && tx_ready_i |=> !tx_valid_o)
        else $error("identifier offered twice");

    // Commands stay above group one so group-one slave answers win arbitration
    a_cmd_low_prio: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        tx_valid_o |-> tx_id_o > G1_LAST)
        else $error("command in group one");

    a_refused_quiet: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        take && !io_open_o && (cmd_kind_i == PDC_CMD_STROBE
        || cmd_kind_i == PDC_CMD_MC_POLL || cmd_kind_i == PDC_CMD_COS_ACK)
        |=> cmd_error_o && !tx_valid_o)
        else $error("io command sent without connection");

    a_expl_accepted: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        take && cmd_kind_i == PDC_CMD_EXPL
        |=> tx_valid_o && !cmd_error_o && expl_open_o)
        else $error("explicit request refused");

    // ------------------------------------------------------------
    // Receive checks
    // ------------------------------------------------------------

    a_io_after_rsp: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        state_reg == PDC_ST_EXPL && rx_evt_o
        && rx_kind_o == PDC_RX_EXPL_RSP && rx_mac_o == target_reg
        |=> io_open_o)
        else $error("io connection did not open");

    a_poll_rsp_kind: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        rx_valid_i && rx_id_i[10:6] == {G1_PREFIX, G1_POLL_RSP}
        |=> rx_kind_o == PDC_RX_POLL_RSP
        && rx_mac_o == $past(rx_id_i[5:0]))
        else $error("poll response decode wrong");

    a_rx_mac_g2: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        rx_valid_i && rx_id_i[10:9] == G2_PREFIX
        |=> rx_mac_o == $past(rx_id_i[8:3]))
        else $error("group two address decode wrong");

    // Groups three and four carry nothing this connection set uses
    a_rx_other_far: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        rx_valid_i && rx_id_i > G2_LAST
        |=> rx_kind_o == PDC_RX_OTHER)
        else $error("group three or four decode wrong");

    a_io_needs_rsp: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        $rose(io_open_o) |-> $past(rx_evt_o)
        && $past(rx_kind_o) == PDC_RX_EXPL_RSP)
        else $error("io connection opened without response");

endmodule // pdc_master

// ---- pdc_master_tb.sv ----
module pdc_master_tb
    import pdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [5:0] NODE = 6'h01;
    localparam logic [5:0] MC = 6'h3E;

    logic sys_clk, srst, cmd_valid, inj_valid, slow, cos;
    logic [5:0] own_mac, cmd_mac, rx_mac;
    logic [10:0] inj_id, m_rx_id, tx_id;
    pdc_cmd_t cmd_kind;
    pdc_rx_kind_t rx_kind;
    logic cmd_ready, tx_valid, tx_ready, m_rx_valid, rx_evt;
    logic rx_expected, expl_open, io_open, cmd_error;
    int bad_count = 0;
    int check_count = 0;
    pdc_cmd_t ks[6] = '{PDC_CMD_STROBE, PDC_CMD_MC_POLL, PDC_CMD_COS_ACK,
        PDC_CMD_POLL, PDC_CMD_UNCONN, PDC_CMD_DUP};
    logic [5:0] ms[6] = '{NODE, MC, NODE, NODE, NODE, NODE};
    pdc_rx_kind_t eks[6] = '{PDC_RX_STROBE_RSP, PDC_RX_MC_POLL_RSP,
        PDC_RX_NONE, PDC_RX_POLL_RSP, PDC_RX_EXPL_RSP, PDC_RX_DUP_CHECK};

    always #5 sys_clk = ~sys_clk;

    pdc_master u_dut (.sys_clk_i(sys_clk), .srst_i(srst),
        .own_mac_i(own_mac), .cmd_valid_i(cmd_valid),
        .cmd_ready_o(cmd_ready), .cmd_kind_i(cmd_kind),
        .cmd_mac_i(cmd_mac), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
        .tx_id_o(tx_id), .rx_valid_i(m_rx_valid || inj_valid),
        .rx_id_i(inj_valid ? inj_id : m_rx_id), .rx_evt_o(rx_evt),
        .rx_kind_o(rx_kind), .rx_mac_o(rx_mac),
        .rx_expected_o(rx_expected), .expl_open_o(expl_open),
        .io_open_o(io_open), .cmd_error_o(cmd_error));

    pdc_slave_model #(.NODE_MAC(NODE), .MC_MAC(MC)) u_slave (
        .sys_clk_i(sys_clk), .srst_i(srst), .tx_valid_i(tx_valid),
        .tx_id_i(tx_id), .tx_ready_o(tx_ready), .rx_valid_o(m_rx_valid),
        .rx_id_o(m_rx_id), .slow_i(slow), .cos_i(cos));

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [10:0] e,
                       input logic [10:0] g);
        check_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic timeout();
        bad_count++;
        $display("Error handshake expected done seen timeout");
        finish_test();
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic do_cmd(input pdc_cmd_t k, input logic [5:0] m,
                          input bit refuse, input pdc_rx_kind_t ek);
        int n;
        logic [10:0] eid;
        eid = {G2_PREFIX, (k == PDC_CMD_STROBE) ? own_mac : m, k};
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        cmd_mac <= m;
        @(negedge sys_clk);
        n = 0;
        while (cmd_ready !== 1'b1 && n < 20)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (cmd_ready !== 1'b1) timeout();
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        @(negedge sys_clk);
        chk("cmd_error", 11'(refuse), 11'(cmd_error));
        chk("tx_valid", 11'(!refuse), 11'(tx_valid));
        if (refuse) return;
        n = 0;
        while (tx_ready !== 1'b1 && n < 20)
        begin
            chk("tx_id", eid, tx_id);
            @(negedge sys_clk);
            n++;
        end
        chk("tx_id", eid, tx_id);
        if (tx_ready !== 1'b1) timeout();
        n = 0;
        while (rx_evt !== 1'b1 && n < 6)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (ek != PDC_RX_NONE && rx_evt !== 1'b1) timeout();
        if (ek == PDC_RX_NONE)
            chk("rx_evt", 11'h0, 11'(rx_evt));
        else
        begin
            chk("rx_kind", 11'(ek), 11'(rx_kind));
            chk("rx_mac", 11'(NODE), 11'(rx_mac));
            chk("rx_expected", 11'h1, 11'(rx_expected));
        end
    endtask

    task automatic inject(input logic [10:0] id, input pdc_rx_kind_t ek,
                          input logic [5:0] em, input logic ee);
        @(posedge sys_clk);
        inj_valid <= 1'b1;
        inj_id <= id;
        @(posedge sys_clk);
        inj_valid <= 1'b0;
        @(negedge sys_clk);
        chk("rx_evt", 11'h1, 11'(rx_evt));
        chk("rx_kind", 11'(ek), 11'(rx_kind));
        if (ek != PDC_RX_OTHER)
        begin
            chk("rx_mac", 11'(em), 11'(rx_mac));
            chk("rx_expected", 11'(ee), 11'(rx_expected));
        end
    endtask

    task automatic reset_check();
        chk("cmd_ready", 11'h1, 11'(cmd_ready));
        chk("open", 11'h0, 11'({expl_open, io_open, tx_valid}));
        chk("rx_kind", 11'(PDC_RX_NONE), 11'(rx_kind));
        chk("flags", 11'h0, 11'({rx_evt, rx_expected, cmd_error}));
    endtask

    task automatic cos_frame();
        @(posedge sys_clk);
        cos <= 1'b1;
        @(posedge sys_clk);
        cos <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk("rx_evt", 11'h1, 11'(rx_evt));
        chk("rx_kind", 11'(PDC_RX_COS_DATA), 11'(rx_kind));
        chk("rx_mac", 11'(NODE), 11'(rx_mac));
        chk("rx_expected", 11'h0, 11'(rx_expected));
    endtask

    // Reset in mid-run must close both connections again
    task automatic mid_reset();
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        @(negedge sys_clk);
        reset_check();
        do_cmd(PDC_CMD_POLL, NODE, 1'b1, PDC_RX_NONE);
        do_cmd(PDC_CMD_EXPL, NODE, 1'b0, PDC_RX_EXPL_RSP);
        do_cmd(PDC_CMD_POLL, NODE, 1'b0, PDC_RX_POLL_RSP);
    endtask

    initial
    begin
        sys_clk = 1'b0;
        srst = 1'b1;
        own_mac = 6'h2A;
        cmd_valid = 1'b0;
        cmd_kind = PDC_CMD_EXPL;
        cmd_mac = 6'h00;
        inj_valid = 1'b0;
        inj_id = 11'h000;
        slow = 1'b0;
        cos = 1'b0;
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        @(negedge sys_clk);
        reset_check();
        inject(11'h40B, PDC_RX_EXPL_RSP, NODE, 1'b1);
        for (int i = 0; i < 4; i++)
            do_cmd(ks[i], ms[i], 1'b1, PDC_RX_NONE);
        @(posedge sys_clk);
        slow <= 1'b1;
        do_cmd(PDC_CMD_EXPL, NODE, 1'b0, PDC_RX_EXPL_RSP);
        @(negedge sys_clk);
        chk("io_open", 11'h3, 11'({expl_open, io_open}));
        @(posedge sys_clk);
        slow <= 1'b0;
        // Commands of every remaining kind, each after the answer to the last
        for (int i = 0; i < 6; i++)
            do_cmd(ks[i], ms[i], 1'b0, eks[i]);
        do_cmd(PDC_CMD_EXPL, 6'h05, 1'b0, PDC_RX_NONE);
        inject(11'h42B, PDC_RX_EXPL_RSP, 6'h05, 1'b1);
        inject(11'h40B, PDC_RX_EXPL_RSP, NODE, 1'b0);
        inject(11'h3FF, PDC_RX_POLL_RSP, 6'h3F, 1'b0);
        inject(11'h5FF, PDC_RX_DUP_CHECK, 6'h3F, 1'b0);
        inject(11'h600, PDC_RX_OTHER, 6'h00, 1'b0);
        inject(11'h7BF, PDC_RX_OTHER, 6'h00, 1'b0);
        inject(11'h7C0, PDC_RX_OTHER, 6'h00, 1'b0);
        inject(11'h7EF, PDC_RX_OTHER, 6'h00, 1'b0);
        cos_frame();
        mid_reset();
        finish_test();
    end
endmodule // pdc_master_tb

// ---- pdc_pkg.sv ----
package pdc_pkg;

    localparam int ID_W = 11;
    localparam int MAC_W = 6;
    localparam int G1C_W = 4;
    localparam int G2C_W = 3;

    // Group boundaries
    localparam logic [10:0] G1_LAST = 11'h3FF;
    localparam logic [10:0] G2_LAST = 11'h5FF;
    localparam logic [10:0] G3_LAST = 11'h7BF;
    localparam logic [10:0] G4_LAST = 11'h7EF;
    localparam logic [1:0] G2_PREFIX = 2'h2;
    localparam logic G1_PREFIX = 1'h0;

    // Group-one codes sent by the slave
    localparam logic [3:0] G1_MC_POLL_RSP = 4'hC;
    localparam logic [3:0] G1_COS_DATA = 4'hD;
    localparam logic [3:0] G1_STROBE_RSP = 4'hE;
    localparam logic [3:0] G1_POLL_RSP = 4'hF;

    // Group-two codes
    localparam logic [2:0] G2_STROBE_CMD = 3'h0;
    localparam logic [2:0] G2_MC_POLL_CMD = 3'h1;
    localparam logic [2:0] G2_COS_ACK = 3'h2;
    localparam logic [2:0] G2_SLAVE_EXPL = 3'h3;
    localparam logic [2:0] G2_EXPL_REQ = 3'h4;
    localparam logic [2:0] G2_POLL_CMD = 3'h5;
    localparam logic [2:0] G2_UNCONN_REQ = 3'h6;
    localparam logic [2:0] G2_DUP_CHECK = 3'h7;

    localparam logic [5:0] MAC_DEFAULT = 6'h01;
    localparam logic [5:0] MAC_MAX = 6'h3F;

    typedef enum logic [3:0] {
        PDC_GRP_1 = 4'h1,
        PDC_GRP_2 = 4'h2,
        PDC_GRP_3 = 4'h4,
        PDC_GRP_4 = 4'h8
    } pdc_group_t;

    // Kind of message the master wants to send
    typedef enum logic [2:0] {
        PDC_CMD_STROBE = 3'h0,
        PDC_CMD_MC_POLL = 3'h1,
        PDC_CMD_COS_ACK = 3'h2,
        PDC_CMD_EXPL = 3'h4,
        PDC_CMD_POLL = 3'h5,
        PDC_CMD_UNCONN = 3'h6,
        PDC_CMD_DUP = 3'h7
    } pdc_cmd_t;

    // Kind of frame the master has received from a slave
    typedef enum logic [3:0] {
        PDC_RX_NONE = 4'h0,
        PDC_RX_MC_POLL_RSP = 4'h1,
        PDC_RX_COS_DATA = 4'h2,
        PDC_RX_STROBE_RSP = 4'h3,
        PDC_RX_POLL_RSP = 4'h4,
        PDC_RX_EXPL_RSP = 4'h5,
        PDC_RX_DUP_CHECK = 4'h6,
        PDC_RX_OTHER = 4'h7
    } pdc_rx_kind_t;

    typedef enum logic [2:0] {
        PDC_ST_IDLE = 3'h1,
        PDC_ST_EXPL = 3'h2,
        PDC_ST_IO = 3'h4
    } pdc_state_t;

    function automatic pdc_group_t pdc_group_of(input logic [10:0] id);
        if (id <= G1_LAST)
            return PDC_GRP_1;
        else if (id <= G2_LAST)
            return PDC_GRP_2;
        else if (id <= G3_LAST)
            return PDC_GRP_3;
        else
            return PDC_GRP_4;
    endfunction

    function automatic logic [10:0] pdc_g2_id(input logic [5:0] mac,
                                              input logic [2:0] code);
        return {G2_PREFIX, mac, code};
    endfunction

endpackage

// ---- pdc_rx_decode.sv ----
module pdc_rx_decode
    import pdc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Received identifier
    input wire logic rx_valid_i,
    input wire logic [10:0] rx_id_i,
    // Decoded result
    output logic dec_valid_o,
    output pdc_group_t dec_group_o,
    output pdc_rx_kind_t dec_kind_o,
    output logic [5:0] dec_mac_o
);

    pdc_group_t grp;
    pdc_rx_kind_t kind;
    logic [5:0] mac;

    always_comb
    begin
        grp = pdc_group_of(rx_id_i);
        kind = PDC_RX_OTHER;
        mac = rx_id_i[5:0];
        if (grp == PDC_GRP_1)
        begin
            case (rx_id_i[9:6])
                G1_MC_POLL_RSP: kind = PDC_RX_MC_POLL_RSP;
                G1_COS_DATA: kind = PDC_RX_COS_DATA;
                G1_STROBE_RSP: kind = PDC_RX_STROBE_RSP;
                G1_POLL_RSP: kind = PDC_RX_POLL_RSP;
                default: kind = PDC_RX_OTHER;
            endcase
        end
        else if (grp == PDC_GRP_2)
        begin
            mac = rx_id_i[8:3];
            if (rx_id_i[2:0] == G2_SLAVE_EXPL)
                kind = PDC_RX_EXPL_RSP;
            else if (rx_id_i[2:0] == G2_DUP_CHECK)
                kind = PDC_RX_DUP_CHECK;
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            dec_valid_o <= 1'b0;
            dec_group_o <= PDC_GRP_1;
            dec_kind_o <= PDC_RX_NONE;
            dec_mac_o <= 6'h00;
        end
        else
        begin
            dec_valid_o <= rx_valid_i;
            if (rx_valid_i)
            begin
                dec_group_o <= grp;
                dec_kind_o <= kind;
                dec_mac_o <= mac;
            end
        end
    end

    a_dec_latency: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        rx_valid_i |=> dec_valid_o)
        else $error("decode valid missing");

    a_dec_group_two: assert property (@(posedge sys_clk_i)
        disable iff (srst_i)
        rx_valid_i && rx_id_i[10:9] == G2_PREFIX
        |=> dec_group_o == PDC_GRP_2)
        else $error("group two decode wrong");

endmodule // pdc_rx_decode

// ---- pdc_slave_model.sv ----
module pdc_slave_model
    import pdc_pkg::*;
#(
    parameter logic [5:0] NODE_MAC = 6'h01,
    parameter logic [5:0] MC_MAC = 6'h3E
)
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Identifier from the master
    input wire logic tx_valid_i,
    input wire logic [10:0] tx_id_i,
    output logic tx_ready_o,
    // Identifier back to the master
    output logic rx_valid_o,
    output logic [10:0] rx_id_o,
    // Bench controls
    input wire logic slow_i,
    input wire logic cos_i
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] wait_reg;
    logic expl_reg;
    logic take;
    logic hit;
    logic [10:0] resp;
    logic [5:0] dst;

    assign take = tx_valid_i && tx_ready_o;
    assign dst = tx_id_i[8:3];
    // Slow mode holds the master off for three cycles
    assign tx_ready_o = tx_valid_i && (!slow_i || wait_reg == 2'h3);

    always_ff @(posedge sys_clk_i)
        if (srst_i || !tx_valid_i || take)
            wait_reg <= 2'h0;
        else
            wait_reg <= wait_reg + 2'h1;

    // ----------------------------------------
    // Answer selection
    // ----------------------------------------
    always_comb
    begin
        hit = 1'b0;
        resp = {G2_PREFIX, NODE_MAC, G2_SLAVE_EXPL};
        if (take && tx_id_i[10:9] == G2_PREFIX)
            case (tx_id_i[2:0])
                G2_EXPL_REQ, G2_UNCONN_REQ:
                    hit = (dst == NODE_MAC);
                G2_POLL_CMD:
                begin
                    hit = (dst == NODE_MAC) && expl_reg;
                    resp = {G1_PREFIX, G1_POLL_RSP, NODE_MAC};
                end
                G2_STROBE_CMD:
                begin
                    hit = expl_reg;
                    resp = {G1_PREFIX, G1_STROBE_RSP, NODE_MAC};
                end
                G2_MC_POLL_CMD:
                begin
                    hit = (dst == MC_MAC) && expl_reg;
                    resp = {G1_PREFIX, G1_MC_POLL_RSP, NODE_MAC};
                end
                G2_DUP_CHECK:
                begin
                    hit = (dst == NODE_MAC);
                    resp = {G2_PREFIX, NODE_MAC, G2_DUP_CHECK};
                end
                default: ; // Acknowledges need no answer
            endcase
        if (cos_i)
        begin
            hit = 1'b1;
            resp = {G1_PREFIX, G1_COS_DATA, NODE_MAC};
        end
    end

    always_ff @(posedge sys_clk_i)
        if (srst_i)
            expl_reg <= 1'b0;
        else if (take && tx_id_i[2:0] == G2_EXPL_REQ && dst == NODE_MAC)
            expl_reg <= 1'b1;

    // Idle identifier toggles so a stale value is never mistaken for data
    always_ff @(posedge sys_clk_i)
    begin
        rx_valid_o <= hit && !srst_i;
        rx_id_o <= hit ? resp : ~rx_id_o;
    end
endmodule // pdc_slave_model
